// File: hw/dpbc_regs.vh
// Constants for the DAC power-on / supply-droop reset control block.
// Assumes inclusion by the design file only; definitions only.
`ifndef DPBC_REGS_VH
`define DPBC_REGS_VH

`define DPBC_SHIFT_DEFAULT  8'h40
`define DPBC_WIPER_DEFAULT  7'h20
`define DPBC_WIPER_W        7
`define DPBC_SHIFT_W        8

`define DPBC_PIN_COUNT      2
`define DPBC_SCL_BIT        0
`define DPBC_SDA_BIT        1
`define DPBC_LINE_IDLE      1'h1

`define DPBC_ST_HELD        2'h0
`define DPBC_ST_LOAD        2'h1
`define DPBC_ST_RUN         2'h2

`endif

// File: hw/dpbc_power_control.v
// Reset and power-state control for a volatile 7-bit DAC wiper.
// Assumes bus pins and the supply trip input arrive asynchronously; the
// command decoder sits elsewhere and presents wiper and shift register
// loads on same-clock strobes.
//
// Operation
// - On reset release load shift register with 40h and wiper with 20h.
// - After reset release enable digital operation and accept serial transactions.
// - While supply droop reset is asserted, disable interface and ignore bus.
// - Wiper setting held in 7-bit volatile register, reinitialised at every release.
// - A Stop condition puts the interface into the static state.
// - A Start condition makes the interface active, leaving the static state.
// - Start is data falling while clock is high.
// - Stop is data rising while clock is high.

`timescale 1ns/1ps
`default_nettype none
`include "dpbc_regs.vh"

module dpbc_power_control (
  input  wire                      clk,
  input  wire                      reset,
  input  wire                      supply_droop_reset_n,
  input  wire                      scl_in,
  input  wire                      sda_in,
  input  wire                      wr_valid,
  input  wire [`DPBC_WIPER_W-1:0]  wr_data,
  input  wire                      shift_load,
  input  wire [`DPBC_SHIFT_W-1:0]  shift_data,
  output reg  [`DPBC_WIPER_W-1:0]  wiper_setting,
  output reg  [`DPBC_SHIFT_W-1:0]  serial_shift_register,
  output reg                       digital_enable,
  output reg                       serial_active,
  output reg                       start_seen,
  output reg                       stop_seen
);

  // State codes stay binary so the state fits a two-bit register; in_state decodes it
  localparam [1:0] ST_HELD = `DPBC_ST_HELD;
  localparam [1:0] ST_LOAD = `DPBC_ST_LOAD;
  localparam [1:0] ST_RUN  = `DPBC_ST_RUN;

  wire                       droop_any;
  reg                        droop_s1;
  reg                        droop_s2;
  reg  [1:0]                 state;
  reg  [1:0]                 next_state;
  wire [`DPBC_PIN_COUNT-1:0] pin_raw;
  wire [`DPBC_PIN_COUNT-1:0] pin_now;
  wire [`DPBC_PIN_COUNT-1:0] pin_prev;
  wire                       load_phase;
  wire                       run_phase;
  wire                       start_cond;
  wire                       stop_cond;
  reg  [`DPBC_WIPER_W-1:0]   next_wiper;
  reg  [`DPBC_SHIFT_W-1:0]   next_shift;
  reg                        next_enable;
  reg                        next_active;
  reg                        next_start;
  reg                        next_stop;
  genvar                     g;

  // Shared state decode for the load and run phases
  function in_state;
    input [1:0] current;
    input [1:0] code;
    begin
      in_state = (current == code);
    end
  endfunction

  // One decoder serves both conditions so Start and Stop share their timing
  function bus_cond;
    input [`DPBC_PIN_COUNT-1:0] prev;
    input [`DPBC_PIN_COUNT-1:0] cur;
    input                       data_rises;
    begin
      bus_cond = prev[`DPBC_SCL_BIT] & cur[`DPBC_SCL_BIT] &
                 (prev[`DPBC_SDA_BIT] ^ cur[`DPBC_SDA_BIT]) &
                 (cur[`DPBC_SDA_BIT] == data_rises);
    end
  endfunction

  // Either reset source holds the block; assertion acts at once
  // Limitation: a droop shorter than a clock period still resets everything,
  // since the reset path is asynchronous and needs no clock
  assign droop_any = reset | ~supply_droop_reset_n;

  // Release passes two stages so defaults load on a clean edge
  always @(posedge clk or posedge droop_any) begin
    if (droop_any) begin
      droop_s1 <= 1'h0;
      droop_s2 <= 1'h0;
    end else begin
      droop_s1 <= 1'h1;
      droop_s2 <= droop_s1;
    end
  end

  // Release takes two sync edges, one edge into load and one to load
  // defaults; strobes are honoured from the fifth edge on
  always @* begin
    next_state = state;
    case (state)
      ST_HELD: begin
        if (droop_s2) begin
          next_state = ST_LOAD;
        end
      end
      ST_LOAD: begin
        next_state = ST_RUN;
      end
      ST_RUN: begin
        next_state = ST_RUN;
      end
      default: begin
        next_state = ST_HELD;
      end
    endcase
  end

  always @(posedge clk or posedge droop_any) begin
    if (droop_any) begin
      state <= ST_HELD;
    end else begin
      state <= next_state;
    end
  end

  assign pin_raw[`DPBC_SCL_BIT] = scl_in;
  assign pin_raw[`DPBC_SDA_BIT] = sda_in;

  // First stage feeds only the second; the third keeps the previous settled
  // sample. Idle-high reset values keep a false edge from following release.
  generate
    for (g = 0; g < `DPBC_PIN_COUNT; g = g + 1) begin : pin_sync
      reg stage1;
      reg stage2;
      reg stage3;
      always @(posedge clk or posedge droop_any) begin
        if (droop_any) begin
          stage1 <= `DPBC_LINE_IDLE;
          stage2 <= `DPBC_LINE_IDLE;
          stage3 <= `DPBC_LINE_IDLE;
        end else begin
          stage1 <= pin_raw[g];
          stage2 <= stage1;
          stage3 <= stage2;
        end
      end
      assign pin_now[g]  = stage2;
      assign pin_prev[g] = stage3;
    end
  endgenerate

  // Strobes and bus conditions count only in the run phase; everything
  // else is ignored until digital operation is enabled
  assign load_phase = in_state(state, ST_LOAD);
  assign run_phase  = in_state(state, ST_RUN);

  // Clock must be high on both samples so a clock edge is not mistaken
  assign start_cond = run_phase & bus_cond(pin_prev, pin_now, 1'h0);
  assign stop_cond  = run_phase & bus_cond(pin_prev, pin_now, 1'h1);

  always @* begin
    next_wiper  = wiper_setting;
    next_shift  = serial_shift_register;
    next_enable = digital_enable;
    next_active = serial_active;
    next_start  = 1'h0;
    next_stop   = 1'h0;
    if (load_phase) begin
      next_wiper  = `DPBC_WIPER_DEFAULT;
      next_shift  = `DPBC_SHIFT_DEFAULT;
      next_enable = 1'h1;
      next_active = 1'h0;
    end
    if (run_phase) begin
      // Writes that a droop interrupted leave the value to the master
      if (wr_valid) begin
        next_wiper = wr_data;
      end
      if (shift_load) begin
        next_shift = shift_data;
      end
    end
    // Start wins; both in one sample cannot come from a legal bus
    if (start_cond) begin
      next_active = 1'h1;
      next_start  = 1'h1;
    end else if (stop_cond) begin
      next_active = 1'h0;
      next_stop   = 1'h1;
    end
  end

  // Outputs are registered directly so nothing combinational reaches a pin
  always @(posedge clk or posedge droop_any) begin
    if (droop_any) begin
      wiper_setting         <= `DPBC_WIPER_DEFAULT;
      serial_shift_register <= `DPBC_SHIFT_DEFAULT;
      digital_enable        <= 1'h0;
      serial_active         <= 1'h0;
      start_seen            <= 1'h0;
      stop_seen             <= 1'h0;
    end else begin
      wiper_setting         <= next_wiper;
      serial_shift_register <= next_shift;
      digital_enable        <= next_enable;
      serial_active         <= next_active;
      start_seen            <= next_start;
      stop_seen             <= next_stop;
    end
  end

endmodule

`default_nettype wire

// File: bench/dpbc_checker.sv
// Checker on the power control ports; assumes one clock and the bind below.
`timescale 1ns/1ps
`default_nettype none
module dpbc_checker (input wire logic clk, reset, supply_droop_reset_n, scl_in, sda_in,
  digital_enable, serial_active, start_seen, stop_seen, input wire logic [6:0] wiper_setting,
  input wire logic [7:0] serial_shift_register);
  wire p = supply_droop_reset_n, e = digital_enable, a = serial_active;
  wire d = wiper_setting == 7'h20 && serial_shift_register == 8'h40;
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  a_droop_idle: assert property (!p |-> !e && !a) else $error("live");
  a_droop_load: assert property (!p |-> d) else $error("load");
  a_release_wait: assert property ($rose(p) |-> !e [*4] ##1 e) else $error("wait");
  a_enable_load: assert property ($rose(e) |-> d) else $error("dflt");
  a_start_edge: assert property (start_seen |-> scl_in && !sda_in) else $error("sta");
  a_stop_edge: assert property (stop_seen |-> scl_in && sda_in) else $error("sto");
  a_start_busy: assert property (start_seen |-> a) else $error("act");
  a_stop_idle: assert property ($fell(a) |-> stop_seen || !e) else $error("idle");
  a_reset_wait: assert property ($fell(reset) && p |-> !e [*4] ##1 e) else $error("rwait");
  a_droop_quiet: assert property (!p |-> !start_seen && !stop_seen) else $error("quiet");
  cover property ($fell(a));
  cover property ($rose(e));
  cover property (start_seen);
  cover property (stop_seen);
endmodule
bind dpbc_power_control dpbc_checker chk_u (.*);
`default_nettype wire

// File: bench/dpbc_bus_master.sv
// Bus master model; assumes lines idle high as if pulled up.
`timescale 1ns/1ps
`default_nettype none
module dpbc_bus_master (input wire logic clk, output var logic scl = 1'h1, sda = 1'h1);
  task automatic cond(input logic lvl);
    for (int i = 0; i < 12; i++) begin
      @(negedge clk);
      {scl, sda} = {i > 3, i < 2 ? sda : lvl ^ (i < 6)};
    end
  endtask
endmodule
`default_nettype wire

// File: bench/dac_power_on_brownout_control_bench.sv
// Bench: writes, bus conditions and a droop; assumes the master model.
`timescale 1ns/1ps
`default_nettype none
module dac_power_on_brownout_control_bench;
  logic clk = 1'h0, reset = 1'h1, p_n = 1'h1, wv = 1'h0, sl = 1'h0;
  logic [7:0] d = 8'h00;
  logic [1:0] starts = 2'h0, stops = 2'h0;
  wire scl, sda, de, sa, ss, sp;
  wire [6:0] w;
  wire [7:0] s;
  wire [20:0] obs = {stops, starts, de, sa, w, s};
  int miscompares = 0, checks_done = 0;
  initial forever #2.5 clk = ~clk;
  dpbc_bus_master m_u (.clk, .scl, .sda);
  dpbc_power_control dut_u (.clk, .reset, .supply_droop_reset_n(p_n), .scl_in(scl),
    .sda_in(sda), .wr_valid(wv), .wr_data(d[6:0]), .shift_load(sl), .shift_data(d),
    .wiper_setting(w), .serial_shift_register(s), .digital_enable(de),
    .serial_active(sa), .start_seen(ss), .stop_seen(sp));
  // Pulses stand one cycle, so they are counted where they are settled
  always @(negedge clk) begin
    starts <= starts + {1'h0, ss};
    stops  <= stops + {1'h0, sp};
  end
  task automatic test_done;
    if (miscompares == 0 && checks_done > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task automatic chk(input logic [20:0] seen, input logic [20:0] exp);
    checks_done++;
    if (seen !== exp) begin
      miscompares++;
      $display("mismatch %0t saw %h expected %h", $time, seen, exp);
    end
  endtask
  // A release that never enables counts as a mismatch; the rest stays bounded
  task automatic up;
    for (int i = 0; i < 20 && de !== 1'h1; i++) @(negedge clk);
    if (de !== 1'h1) begin
      miscompares++;
      $display("mismatch %0t enable never rose", $time);
    end
  endtask
  task automatic put(input logic f, input logic [7:0] v);
    @(negedge clk) {wv, sl, d} = {f, !f, v};
    @(negedge clk) {wv, sl} = 2'h0;
  endtask
  initial begin
    repeat (5) @(negedge clk);
    reset = 1'h0;
    up;
    chk(obs, 21'h12040);
    put(1'h1, 8'h55);
    put(1'h0, 8'hA3);
    chk(obs, 21'h155A3);
    m_u.cond(1'h0);
    chk(obs, 21'h3D5A3);
    m_u.cond(1'h1);
    chk(obs, 21'hB55A3);
    p_n = 1'h0;
    m_u.cond(1'h0);
    put(1'h1, 8'h11);
    chk(obs, 21'hA2040);
    m_u.cond(1'h1);
    p_n = 1'h1;
    up;
    chk(obs, 21'hB2040);
    // The master rewrites the wiper after the supply recovers
    put(1'h1, 8'h55);
    chk(obs, 21'hB5540);
    test_done;
  end
endmodule
`default_nettype wire
